// *** pkg/sdmrs_pkg.sv ***
// Constants for the SDRAM mode register setup block.
// Assumes a 32-bit CPU address bus and one bus clock.
package sdmrs_pkg;
  // ==========================================
  // Trigger address windows
  localparam logic [31:0] AREA3_BASE = 32'hFFF8_5000;
  localparam logic [31:0] AREA2_BASE = 32'hFFF8_4000;
  localparam logic [31:0] WINDOW_MASK = 32'hFFFF_F000;
  // ==========================================
  // Command sequence
  localparam logic [3:0] REFRESH_COUNT = 4'h8;
  // SDRAM command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_PALL = 4'h2;
  localparam logic [3:0] CMD_AREF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  // ==========================================
  // Mode field positions in the SDRAM address
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_WT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_OP_LSB = 7;
  localparam int MODE_WIDTH = 11;
  localparam int SDRAM_ADDR_W = 15;
  typedef enum logic {BUS16, BUS32} sdmrs_width_e;
endpackage : sdmrs_pkg

// *** pkg/sdmrs_cmd_if.sv ***
// Command carrier between the sequencer and the command driver.
// Assumes both ends share I_CLK.
`timescale 1ns/1ps
`default_nettype none
interface sdmrs_cmd_if;
  logic [3:0] cmd;
  logic [14:0] addr;
  logic area3;
  modport seq (output cmd, output addr, output area3);
  modport drv (input cmd, input addr, input area3);
endinterface : sdmrs_cmd_if
`default_nettype wire

// *** core/sdmrs_drv.sv ***
// Registers the command onto the SDRAM pins.
// Assumes the sequencer holds commands stable for one cycle each.
`timescale 1ns/1ps
`default_nettype none
module sdmrs_drv (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Command
  sdmrs_cmd_if.drv c,
  // Pins
  output logic [3:0] o_cmd,
  output logic [14:0] o_addr,
  output logic [1:0] o_cs_b
);
  // ==========================================
  // Chip select decode: only the addressed area sees the command
  wire logic cs_active = ~c.cmd[3];
  wire logic [1:0] cs_b_nxt = cs_active ? (c.area3 ? 2'b01 : 2'b10) : 2'b11;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      o_cmd <= sdmrs_pkg::CMD_NOP;
      o_addr <= 15'h0000;
      o_cs_b <= 2'b11;
    end else begin
      o_cmd <= c.cmd;
      o_addr <= c.addr;
      o_cs_b <= cs_b_nxt;
    end
  end
endmodule : sdmrs_drv
`default_nettype wire

// *** core/sdmrs_top.sv ***
// SDRAM mode register setup sequencer.
// Assumes a synchronous CPU write strobe and an SDRAM on area 2 or 3.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1 - Mode value goes out on SDRAM address lines, not data lines
// RULE2 - Burst read/single or burst write, length 1, sequential, CAS 2 or 3
// RULE3 - Word write to area 3 window at 0xFFF85000 plus mode starts setup
// RULE4 - Word write to area 2 window at 0xFFF84000 plus mode starts setup
// RULE5 - Host uses offset 0x440 or 0x460 for 16-bit area 2 CAS 2/3
// RULE6 - SDRAM address bit 11 upward driven low during mode set
// RULE7 - 16-bit bus: CPU A0 unused, CPU A1 drives SDRAM A0
// RULE8 - 32-bit bus: CPU A0 and A1 unused, mapping starts at A2
// RULE9 - Host shifts mode value left one bit to form the offset
// RULE10 - Map A1-3 burst, A4 wrap, A5-7 CAS, A8-11 op mode
// RULE11 - Issue precharge all, eight auto-refreshes, then mode write
// RULE12 - Area usable for normal access once mode write is issued
// RULE13 - Host waits SDRAM power-on idle time before triggering
// RULE14 - Write data ignored; bus cycle ends after the whole sequence
module sdmrs_top #(
  parameter sdmrs_pkg::sdmrs_width_e BUS_WIDTH = sdmrs_pkg::BUS16
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // CPU bus
  input wire logic I_WR,
  input wire logic I_WORD,
  input wire logic [31:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  output logic O_READY,
  // SDRAM
  output logic [3:0] O_SD_CMD,
  output logic [14:0] O_SD_ADDR,
  output logic [1:0] O_SD_CS_B,
  // Status
  output logic O_AREA2_READY,
  output logic O_AREA3_READY,
  output logic O_BUSY
);
  // ==========================================
  // Reset release
  logic rst_meta_r;
  logic rst_b_r;
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_meta_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_b_r <= rst_meta_r;
    end
  end

  // ==========================================
  // Trigger decode
  wire logic hit3 = (I_ADDR & sdmrs_pkg::WINDOW_MASK) == sdmrs_pkg::AREA3_BASE; // RULE3
  wire logic hit2 = (I_ADDR & sdmrs_pkg::WINDOW_MASK) == sdmrs_pkg::AREA2_BASE; // RULE4
  // Data word is never looked at; only the address carries the mode
  wire logic trig = I_WR & I_WORD & (hit2 | hit3); // RULE14
  // Word addressing drops A0 on a 16-bit bus, A0-A1 on a 32-bit bus
  wire logic [10:0] mode_16 = I_ADDR[11:1]; // RULE7 RULE10
  wire logic [10:0] mode_32 = {1'b0, I_ADDR[11:2]}; // RULE8
  wire logic [10:0] mode_sel = (BUS_WIDTH == sdmrs_pkg::BUS16) ? mode_16 : mode_32;

  // ==========================================
  // Sequencer
  typedef enum logic [1:0] {IDLE, PALL, AREF, MRS} sdmrs_state_e;
  sdmrs_state_e state_r;
  sdmrs_state_e state_nxt;
  logic [3:0] ref_cnt_r;
  logic [3:0] ref_cnt_nxt;
  logic [10:0] mode_r;
  logic area3_r;
  logic [1:0] ready_r;
  logic [1:0] ready_nxt;

  always_comb begin
    state_nxt = state_r;
    ref_cnt_nxt = ref_cnt_r;
    ready_nxt = ready_r;
    unique case (state_r)
      IDLE: begin
        if (trig) begin
          state_nxt = PALL;
        end
      end
      PALL: begin
        state_nxt = AREF; // RULE11
        ref_cnt_nxt = 4'h0;
      end
      AREF: begin
        ref_cnt_nxt = ref_cnt_r + 4'h1;
        if (ref_cnt_r == sdmrs_pkg::REFRESH_COUNT - 4'h1) begin
          state_nxt = MRS; // RULE11
        end
      end
      MRS: begin
        state_nxt = IDLE;
        ready_nxt[area3_r] = 1'b1; // RULE12
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      state_r <= IDLE;
      ref_cnt_r <= 4'h0;
      mode_r <= 11'h000;
      area3_r <= 1'b0;
      ready_r <= 2'b00;
    end else begin
      state_r <= state_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      ready_r <= ready_nxt;
      if (state_r == IDLE && trig) begin
        mode_r <= mode_sel;
        area3_r <= hit3;
      end
    end
  end

  // ==========================================
  // Command and address
  sdmrs_cmd_if cmd_bus ();
  assign cmd_bus.cmd = (state_r == PALL) ? sdmrs_pkg::CMD_PALL :
                       (state_r == AREF) ? sdmrs_pkg::CMD_AREF :
                       (state_r == MRS) ? sdmrs_pkg::CMD_MRS : sdmrs_pkg::CMD_NOP;
  // A10 high on precharge selects all banks; mode on address, upper bits low
  assign cmd_bus.addr = (state_r == MRS) ? {4'h0, mode_r} : // RULE1 RULE6 RULE2
                        (state_r == PALL) ? 15'h0400 : 15'h0000;
  assign cmd_bus.area3 = area3_r;

  sdmrs_drv u_drv (
    .clk(I_CLK),
    .rst_b(rst_b_r),
    .c(cmd_bus.drv),
    .o_cmd(O_SD_CMD),
    .o_addr(O_SD_ADDR),
    .o_cs_b(O_SD_CS_B)
  );

  // ==========================================
  // Bus handshake: write held until the sequencer is in MRS, the cycle before the mode write reaches the pins
  assign O_READY = (state_r == MRS) | (I_WR & ~trig); // RULE14
  assign O_AREA2_READY = ready_r[0];
  assign O_AREA3_READY = ready_r[1];
  assign O_BUSY = state_r != IDLE;
endmodule : sdmrs_top
`default_nettype wire

// *** bench/sdmrs_asserts.sv ***
// Port checker for the mode setup block.
// Assumes the BUS16 address mapping; bound into sdmrs_top.
`timescale 1ns/1ps
`default_nettype none
module sdmrs_asserts (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_WR,
  input wire logic I_WORD,
  input wire logic [31:0] I_ADDR,
  input wire logic O_READY,
  input wire logic [3:0] O_SD_CMD,
  input wire logic [14:0] O_SD_ADDR,
  input wire logic [1:0] O_SD_CS_B,
  input wire logic O_AREA2_READY,
  input wire logic O_BUSY
);
  // ==========================================
  // Properties
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  wire trig = I_WR && I_WORD && I_ADDR[31:13] == 19'h7_FFC2;
  wire mrs = O_SD_CMD == sdmrs_pkg::CMD_MRS;
  AST_SEQ: assert property (O_SD_CMD == sdmrs_pkg::CMD_PALL |=>
    O_SD_CMD == sdmrs_pkg::CMD_AREF [*8] ##1 mrs) else $error("command order wrong");
  AST_HIGH: assert property (mrs |-> O_SD_ADDR[14:11] == 4'h0) else $error("high bits set");
  AST_MAP: assert property (mrs |-> O_SD_ADDR[10:0] == $past(I_ADDR[11:1])) else $error("bad mode");
  AST_CS: assert property (O_SD_CMD == sdmrs_pkg::CMD_AREF |-> O_SD_CS_B == {!I_ADDR[12], I_ADDR[12]})
    else $error("wrong chip select");
  AST_DONE: assert property (trig && O_READY |=> mrs) else $error("cycle ended early");
  AST_START: assert property ($rose(O_BUSY) |=> O_SD_CMD == sdmrs_pkg::CMD_PALL) else $error("no precharge");
  AST_BYTE: assert property (I_WR && !I_WORD |-> O_READY && !O_BUSY) else $error("byte write held");
  AST_USE: assert property (mrs && !O_SD_CS_B[0] |=> O_AREA2_READY) else $error("area not ready");
  cover property (mrs && !O_SD_CS_B[1]);
  cover property (mrs && !O_SD_CS_B[0]);
  cover property (I_WR && !I_WORD && O_READY);
endmodule : sdmrs_asserts
bind sdmrs_top sdmrs_asserts i_chk (.I_CLK, .I_RST_B, .I_WR, .I_WORD, .I_ADDR, .O_READY, .O_SD_CMD,
  .O_SD_ADDR, .O_SD_CS_B, .O_AREA2_READY, .O_BUSY);
`default_nettype wire

// *** bench/sdmrs_sdram_model.sv ***
// Behavioural SDRAM pair: keeps the mode word and refresh count.
// Assumes commands are taken on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module sdmrs_sdram_model (
  input wire logic clk,
  input wire logic [3:0] cmd,
  input wire logic [14:0] addr,
  input wire logic [1:0] cs_b,
  output logic [10:0] mode_r,
  output logic [1:0] sel_r,
  output logic [3:0] nref_r
);
  wire act = cs_b != 2'b11;
  always_ff @(posedge clk) begin
    if (act && cmd == sdmrs_pkg::CMD_PALL) nref_r <= 4'h0;
    if (act && cmd == sdmrs_pkg::CMD_AREF) nref_r <= nref_r + 4'h1;
    if (act && cmd == sdmrs_pkg::CMD_MRS) begin
      mode_r <= addr[10:0];
      sel_r <= cs_b;
    end
  end
endmodule : sdmrs_sdram_model
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the mode setup block.
// Assumes the BUS16 mapping and the hand-over latencies.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic word = 1'b0;
  logic [31:0] addr = 32'h0000_0000;
  logic [15:0] wdata = 16'h0000;
  logic ready, busy, a2, a3;
  logic [3:0] cmd, nref;
  logic [14:0] sd_addr;
  logic [1:0] cs_b, sel;
  logic [10:0] mode;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  sdmrs_top i_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_WR(wr), .I_WORD(word), .I_ADDR(addr), .I_WDATA(wdata),
    .O_READY(ready), .O_SD_CMD(cmd), .O_SD_ADDR(sd_addr), .O_SD_CS_B(cs_b), .O_AREA2_READY(a2),
    .O_AREA3_READY(a3), .O_BUSY(busy));
  sdmrs_sdram_model i_mem (.clk(clk), .cmd(cmd), .addr(sd_addr), .cs_b(cs_b), .mode_r(mode), .sel_r(sel),
    .nref_r(nref));
  initial forever #5 clk = ~clk;
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task end_sim;
    $display("mismatches %0d checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  // Host word write; the host forms the offset from the mode shifted left
  task mrs(input logic [31:0] a, input logic [10:0] m);
    int n;
    @(negedge clk);
    {wr, word, addr, wdata} = {2'b11, a, ~wdata};
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("latency", 16'(n), 16'h000A);
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
    chk("mode", mode, m);
    chk("refresh", nref, 16'h0008);
    chk("select", sel, a[12] ? 2'b01 : 2'b10);
    chk("usable", a[12] ? a3 : a2, 1'b1);
  endtask : mrs
  task t_byte;
    @(negedge clk);
    {wr, word, addr} = {2'b10, 32'hFFF8_4440};
    @(posedge clk);
    #1 chk("byte", {ready, busy}, 2'b10);
    @(negedge clk);
    wr = 1'b0;
  endtask : t_byte
  task t_area2;
    mrs(32'hFFF8_4440, 11'h220);
    mrs(32'hFFF8_4460, 11'h230);
  endtask : t_area2
  task t_area3;
    mrs(32'hFFF8_5440, 11'h220);
    mrs(32'hFFF8_5060, 11'h030);
  endtask : t_area3
  // Odd address: bit 0 must not reach the mode word
  task t_bounds;
    mrs(32'hFFF8_4FFF, 11'h7FF);
  endtask : t_bounds
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    // Idle time before the first trigger stands in for the SDRAM power-on wait
    repeat (4) @(negedge clk);
    t_byte();
    t_area2();
    t_area3();
    t_bounds();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
